// file: common/spcs_pkg.sv
package spcs_pkg;
  localparam int          SPCS_AW         = 3;
  localparam int          SPCS_DW         = 16;
  localparam logic [2:0]  SPCS_CTL1_OFS   = 3'h0;
  localparam logic [2:0]  SPCS_CTL2_OFS   = 3'h1;
  localparam logic [2:0]  SPCS_CTL3_OFS   = 3'h2;
  localparam logic [2:0]  SPCS_CTL4_OFS   = 3'h3;
  localparam logic [2:0]  SPCS_STS1_OFS   = 3'h4;
  localparam logic [15:0] SPCS_CTL1_RST   = 16'h0185;
  localparam logic [15:0] SPCS_CTL2_RST   = 16'h0007;
  localparam logic [15:0] SPCS_CTL3_RST   = 16'h0002;
  localparam logic [15:0] SPCS_CTL4_RST   = 16'h0000;
  // Control one fields
  localparam int C1_FIBER     = 0;
  localparam int C1_TBI       = 1;
  localparam int C1_SD_EN     = 2;
  localparam int C1_SD_INV    = 3;
  localparam int C1_AUTODET   = 4;
  localparam int C1_SGMII_MST = 5;
  localparam int C1_PLL_KEEP  = 6;
  localparam int C1_CRC_DIS   = 7;
  localparam int C1_COMMA_EN  = 8;
  // Control two fields
  localparam int C2_PAR_DET   = 0;
  localparam int C2_NO_FALSE  = 1;
  localparam int C2_FILT_LINK = 2;
  localparam int C2_AN_ERR_TMR = 3;
  localparam int C2_RF_DIS    = 4;
  localparam int C2_FORCE_TX  = 5;
  localparam int C2_RX_BYP    = 9;
  localparam int C2_TX_BYP    = 10;
  localparam int C2_TEST_CNT  = 11;
  localparam int C2_CLR_BER   = 14;
  // Control three fields
  localparam int C3_TXF_RST   = 0;
  localparam int C3_ELAST_LO  = 1;
  localparam int C3_FL_RX     = 5;
  localparam int C3_FL_TX     = 6;
  localparam int C3_BLK_TXEN  = 9;
  localparam int C3_NO_TXCRS  = 13;
  // Status one sticky positions, low to high
  localparam int S1_EARLY_EXT = 8;
  localparam int S1_NFLAG     = 8;
  // Timing
  localparam int  CLK_HZ          = 10_000_000;
  localparam int  LINK_FILT_MS    = 10;
  localparam int  LINK_FILT_CYC   = LINK_FILT_MS * (CLK_HZ / 1000);
  localparam int  AN_ERR_CYC      = 4000;
  localparam int  IPG_GIG_HALFB   = 14;
  localparam int  IPG_SLOW_HALFB  = 13;
  // Elastic FIFO depth codes
  localparam logic [1:0] SPCS_DEP_5K   = 2'h0;
  localparam logic [1:0] SPCS_DEP_10K  = 2'h1;
  localparam logic [1:0] SPCS_DEP_13K  = 2'h2;
  localparam logic [1:0] SPCS_DEP_MIN  = 2'h3;
  typedef enum logic [2:0] {
    AN_ENABLE  = 3'h0,
    AN_ABILITY = 3'h1,
    AN_ACK     = 3'h2,
    AN_IDLE    = 3'h3,
    AN_LINK    = 3'h4,
    AN_ERROR   = 3'h5
  } spcs_an_t;
endpackage

// file: design/spcs_ctrl.sv
`timescale 1ns/1ns
module spcs_ctrl
  import spcs_pkg::*;
#(
  parameter int unsigned LINK_HOLD = LINK_FILT_CYC
) (
  // Clock, enable, reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        ce_i,
  // Register port
  input  wire logic [spcs_pkg::SPCS_AW-1:0] reg_addr_i,
  input  wire logic [spcs_pkg::SPCS_DW-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [spcs_pkg::SPCS_DW-1:0] reg_rdata_o,
  // Main control register inputs
  input  wire logic                        main_pwrdn_i,
  input  wire logic [2:0]                  main_adv_i,
  input  wire logic                        an_enable_i,
  input  wire logic                        full_duplex_i,
  input  wire logic                        gig_speed_i,
  // Pins and receive events
  input  wire logic                        sig_det_pin_i,
  input  wire logic                        rx_sync_i,
  input  wire logic                        rx_page_i,
  input  wire logic                        rx_page_sel0_i,
  input  wire logic                        rx_page_ack_i,
  input  wire logic                        rx_idle_i,
  input  wire logic                        rx_cw_i,
  input  wire logic                        rx_active_i,
  input  wire logic                        crc_pkt_i,
  input  wire logic                        ber_evt_i,
  input  wire logic [7:0]                  err_evt_i,
  // MAC transmit side
  input  wire logic                        mac_tx_en_i,
  output logic                             tx_en_o,
  output logic                             crs_o,
  // Controls
  output logic                             comma_en_o,
  output logic                             crc_clk_en_o,
  output logic                             pll_pwrdn_o,
  output logic                             sgmii_phy_o,
  output logic      [2:0]                  adv_out_o,
  output logic                             fiber_mode_o,
  output logic                             tbi_sel_o,
  output logic                             sync_allow_o,
  output logic                             tx_byp_o,
  output logic                             rx_byp_o,
  output logic                             link_ok_o,
  output logic                             remote_fault_o,
  output logic                             tx_zero_cfg_o,
  output logic                             an_active_o,
  output logic      [1:0]                  fifo_depth_tx_o,
  output logic      [1:0]                  fifo_depth_rx_o,
  output logic                             txf_rst_o
);
  import spcs_pkg::*;

  logic [15:0] ctl1_reg, ctl2_reg, ctl3_reg, ctl4_reg;
  logic [7:0]  sticky_reg, sticky_next;
  logic [15:0] rdata_reg;
  logic        mode_reg;
  logic [7:0]  ber_reg, pkt_reg;
  logic        sd_s1_reg, sd_s2_reg;
  logic        an_on_reg;
  logic        idle_seen_reg;
  logic        zero_cfg_reg;
  logic        rf_reg;
  logic [11:0] an_tmr_reg;
  logic [4:0]  gap_reg;
  logic        tx_prev_reg;
  spcs_an_t    an_reg, an_next;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
    return a == o;
  endfunction

  wire wr1_w = reg_wr_i && hit(reg_addr_i, SPCS_CTL1_OFS);
  wire wr2_w = reg_wr_i && hit(reg_addr_i, SPCS_CTL2_OFS);
  wire wr3_w = reg_wr_i && hit(reg_addr_i, SPCS_CTL3_OFS);
  wire wr4_w = reg_wr_i && hit(reg_addr_i, SPCS_CTL4_OFS);
  wire rds_w = reg_rd_i && hit(reg_addr_i, SPCS_STS1_OFS);

  // Register writes; clear-BER self-clears next cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl1_reg <= SPCS_CTL1_RST;
      ctl2_reg <= SPCS_CTL2_RST;
      ctl3_reg <= SPCS_CTL3_RST;
      ctl4_reg <= SPCS_CTL4_RST;
    end else if (ce_i) begin
      if (wr1_w) ctl1_reg <= reg_wdata_i;
      if (wr2_w) ctl2_reg <= reg_wdata_i;
      else ctl2_reg[C2_CLR_BER] <= 1'b0;
      if (wr3_w) ctl3_reg <= reg_wdata_i;
      if (wr4_w) ctl4_reg <= reg_wdata_i;
    end
  end

  // Status sticky flags: set wins over read clear
  assign sticky_next = (rds_w ? 8'h0 : sticky_reg) | err_evt_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sticky_reg <= 8'h0;
      rdata_reg  <= 16'h0;
    end else if (ce_i) begin
      sticky_reg <= sticky_next;
      rdata_reg  <= 16'h0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          SPCS_CTL1_OFS: rdata_reg <= ctl1_reg;
          SPCS_CTL2_OFS: rdata_reg <= ctl2_reg;
          SPCS_CTL3_OFS: rdata_reg <= ctl3_reg;
          SPCS_CTL4_OFS: rdata_reg <= ctl4_reg;
          SPCS_STS1_OFS: rdata_reg <= {sticky_reg, 8'h0};
          default:       rdata_reg <= 16'h0;
        endcase
      end
    end
  end
  assign reg_rdata_o = rdata_reg;

  // Simple controls
  assign comma_en_o   = ctl1_reg[C1_COMMA_EN];
  assign crc_clk_en_o = !ctl1_reg[C1_CRC_DIS];
  assign pll_pwrdn_o  = main_pwrdn_i && !ctl1_reg[C1_PLL_KEEP];
  assign sgmii_phy_o  = ctl1_reg[C1_SGMII_MST] && !mode_reg;
  assign adv_out_o    = sgmii_phy_o ? main_adv_i : 3'h0;
  assign tbi_sel_o    = ctl1_reg[C1_TBI];
  assign tx_byp_o     = ctl2_reg[C2_TX_BYP];
  assign rx_byp_o     = ctl2_reg[C2_RX_BYP];
  assign txf_rst_o    = ctl3_reg[C3_TXF_RST];
  assign fiber_mode_o = mode_reg;

  // Mode: fixed by fiber bit or toggled by auto-detect
  wire wrong_sel_w = rx_page_i && (mode_reg ? 1'b0 : !rx_page_sel0_i)
                     || rx_page_i && mode_reg && rx_page_sel0_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_reg <= 1'b1;
    end else if (ce_i) begin
      if (!ctl1_reg[C1_AUTODET]) mode_reg <= ctl1_reg[C1_FIBER];
      else if (wrong_sel_w) mode_reg <= !mode_reg;
    end
  end

  // Signal detect synchroniser and qualification
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sd_s1_reg <= 1'b0;
      sd_s2_reg <= 1'b0;
    end else if (ce_i) begin
      sd_s1_reg <= sig_det_pin_i;
      sd_s2_reg <= sd_s1_reg;
    end
  end
  wire sd_w = sd_s2_reg ^ ctl1_reg[C1_SD_INV];
  assign sync_allow_o = !mode_reg || !ctl1_reg[C1_SD_EN] || sd_w;

  // Counters
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ber_reg <= 8'h0;
      pkt_reg <= 8'h0;
    end else if (ce_i) begin
      if (ctl2_reg[C2_CLR_BER]) ber_reg <= 8'h0;
      else if (ber_evt_i) ber_reg <= ber_reg + 8'h1;
      if (ctl2_reg[C2_TEST_CNT] || crc_pkt_i) pkt_reg <= pkt_reg + 8'h1;
    end
  end

  // Parallel detection and false-link prevention
  wire an_eff_w = ctl2_reg[C2_PAR_DET] ? an_on_reg : an_enable_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an_on_reg     <= 1'b1;
      idle_seen_reg <= 1'b0;
    end else if (ce_i) begin
      if (rx_cw_i) an_on_reg <= 1'b1;
      else if (rx_idle_i) an_on_reg <= 1'b0;
      if (rx_cw_i || !rx_sync_i) idle_seen_reg <= 1'b0;
      else if (rx_idle_i) idle_seen_reg <= 1'b1;
    end
  end
  assign an_active_o = an_eff_w;

  // Link qualification by filter module
  logic sync_stable_w;
  spcs_link_filter #(.HOLD_CYC(LINK_HOLD)) u_filt (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .ce_i     (ce_i),
    .level_i  (rx_sync_i),
    .stable_o (sync_stable_w)
  );
  wire noan_ok_w = (!ctl2_reg[C2_FILT_LINK] || sync_stable_w)
                && (!ctl2_reg[C2_NO_FALSE] || idle_seen_reg);
  assign link_ok_o = rx_sync_i && (an_eff_w ? an_reg == AN_LINK : noan_ok_w);

  // Autonegotiation progress with error timer
  wire tmr_exp_w = ctl2_reg[C2_AN_ERR_TMR]
                && an_tmr_reg == 12'(AN_ERR_CYC - 1);
  always_comb begin
    an_next = an_reg;
    unique case (an_reg)
      AN_ENABLE:  an_next = AN_ABILITY;
      AN_ABILITY: if (tmr_exp_w) an_next = AN_ERROR;
                  else if (rx_page_i) an_next = AN_ACK;
      AN_ACK:     if (tmr_exp_w) an_next = AN_ERROR;
                  else if (rx_page_ack_i) an_next = AN_IDLE;
      AN_IDLE:    if (tmr_exp_w) an_next = AN_ERROR;
                  else if (rx_idle_i) an_next = AN_LINK;
      AN_LINK:    if (!rx_sync_i) an_next = AN_ENABLE;
      AN_ERROR:   if (rx_page_i) an_next = AN_ENABLE;
      default:    an_next = AN_ENABLE;
    endcase
    if (!an_eff_w) an_next = AN_ENABLE;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an_reg     <= AN_ENABLE;
      an_tmr_reg <= 12'h0;
      rf_reg     <= 1'b0;
    end else if (ce_i) begin
      an_reg     <= an_next;
      an_tmr_reg <= (an_next != an_reg) ? 12'h0 : an_tmr_reg + 12'h1;
      if (an_reg == AN_ERROR) rf_reg <= 1'b1;
      else if (an_reg == AN_LINK) rf_reg <= 1'b0;
    end
  end
  assign tx_zero_cfg_o  = an_reg == AN_ERROR;
  assign remote_fault_o = rf_reg && mode_reg && !ctl2_reg[C2_RF_DIS];

  // Transmit gating and gap enforcement
  wire [4:0] gap_min_w = gig_speed_i ? 5'(IPG_GIG_HALFB) : 5'(IPG_SLOW_HALFB);
  // Gap counter steps by two and stops at or above the minimum so it cannot wrap
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_reg     <= 5'h1f;
      tx_prev_reg <= 1'b0;
    end else if (ce_i) begin
      tx_prev_reg <= tx_en_o;
      if (tx_en_o) gap_reg <= 5'h0;
      else if (gap_reg < gap_min_w) gap_reg <= gap_reg + 5'h2;
    end
  end
  // The gap check never cuts a frame already under way
  wire gap_ok_w = !ctl3_reg[C3_BLK_TXEN] || tx_prev_reg
               || gap_reg >= gap_min_w;
  wire pass_w   = ctl2_reg[C2_FORCE_TX] || link_ok_o;
  assign tx_en_o = mac_tx_en_i && pass_w && gap_ok_w && !txf_rst_o;

  // Carrier sense
  assign crs_o = rx_active_i
              || (!full_duplex_i && !ctl3_reg[C3_NO_TXCRS] && tx_en_o);

  // FIFO sizing
  wire [1:0] el_w = ctl3_reg[C3_ELAST_LO+1] ? SPCS_DEP_13K
                  : ctl3_reg[C3_ELAST_LO +: 2];
  assign fifo_depth_tx_o = ctl3_reg[C3_FL_TX] ? SPCS_DEP_MIN : el_w;
  assign fifo_depth_rx_o = ctl3_reg[C3_FL_RX] ? SPCS_DEP_MIN : el_w;

  // Checks
  AST_STICKY_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && err_evt_i[0] |=> sticky_reg[0])
    else $error("sticky flag not set");
  AST_BER_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr2_w && reg_wdata_i[C2_CLR_BER] ##1 ce_i |=>
      ber_reg == 8'h0 && !ctl2_reg[C2_CLR_BER])
    else $error("clear BER failed");
  AST_PLL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctl1_reg[C1_PLL_KEEP] |-> !pll_pwrdn_o)
    else $error("pll powered down");
  AST_TXFRST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    txf_rst_o && !wr3_w |=> txf_rst_o)
    else $error("tx fifo reset released");
  AST_FORCE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tx_en_o |-> ctl2_reg[C2_FORCE_TX] || link_ok_o)
    else $error("tx without link");
  AST_SGMII_SD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !mode_reg |-> sync_allow_o)
    else $error("sd not ignored");
  AST_MODE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !ctl1_reg[C1_AUTODET] |=> mode_reg == $past(ctl1_reg[C1_FIBER]))
    else $error("mode mismatch");
  AST_RF_SGMII: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !mode_reg |-> !remote_fault_o)
    else $error("rf in sgmii");
endmodule

// file: design/spcs_link_filter.sv
`timescale 1ns/1ns
module spcs_link_filter #(
  parameter int unsigned HOLD_CYC = 100000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  // Level in and qualified level out
  input  wire logic level_i,
  output logic      stable_o
);
  logic [23:0] cnt_reg;
  wire         full_w = (cnt_reg >= 24'(HOLD_CYC));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 24'h0;
    end else if (ce_i) begin
      if (!level_i) begin
        cnt_reg <= 24'h0;
      end else if (!full_w) begin
        cnt_reg <= cnt_reg + 24'h1;
      end
    end
  end

  assign stable_o = full_w;
endmodule

// file: tb/spcs_ctrl_tb.sv
`timescale 1ns/1ns
module spcs_ctrl_tb;
  import spcs_pkg::*;
  logic clk_i, rst_b_i, rd, wr, pwrdn, fdx, ber, crc, ce;
  logic [2:0] addr;
  logic [15:0] wdata, rdata;
  logic [7:0] err;
  logic sy, id, cw, pg, s0, ac, mtx, sd;
  logic comma, crcen, pllpd, sgphy, fib, tbi, sya, txb, rxb, lnk, txen, crs;
  logic rf, zcfg, anact, txfr;
  logic [2:0] adv;
  logic [1:0] dtx, drx;
  int errors, comparisons;
  spcs_ctrl #(.LINK_HOLD(20)) i_spcs_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .main_pwrdn_i(pwrdn),
    .main_adv_i(3'h5), .an_enable_i(1'b0), .full_duplex_i(fdx),
    .gig_speed_i(1'b1), .sig_det_pin_i(sd), .rx_sync_i(sy),
    .rx_page_i(pg), .rx_page_sel0_i(s0), .rx_page_ack_i(1'b0),
    .rx_idle_i(id), .rx_cw_i(cw), .rx_active_i(ac), .crc_pkt_i(crc),
    .ber_evt_i(ber), .err_evt_i(err), .mac_tx_en_i(mtx),
    .tx_en_o(txen), .crs_o(crs), .comma_en_o(comma),
    .crc_clk_en_o(crcen), .pll_pwrdn_o(pllpd), .sgmii_phy_o(sgphy),
    .adv_out_o(adv), .fiber_mode_o(fib), .tbi_sel_o(tbi),
    .sync_allow_o(sya), .tx_byp_o(txb), .rx_byp_o(rxb),
    .link_ok_o(lnk), .remote_fault_o(rf), .tx_zero_cfg_o(zcfg),
    .an_active_o(anact), .fifo_depth_tx_o(dtx), .fifo_depth_rx_o(drx),
    .txf_rst_o(txfr));
  spcs_far_model i_spcs_far_model (
    .clk_i(clk_i), .rx_sync_o(sy), .rx_idle_o(id), .rx_cw_o(cw),
    .rx_page_o(pg), .rx_page_sel0_o(s0), .rx_active_o(ac),
    .mac_tx_en_o(mtx), .sig_det_o(sd));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rreg(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    chk(rdata, exp);
  endtask
  task automatic t_reset_map();
    rreg(SPCS_CTL1_OFS, 16'h0185);
    rreg(SPCS_CTL2_OFS, 16'h0007);
    rreg(SPCS_CTL3_OFS, 16'h0002);
    rreg(SPCS_CTL4_OFS, 16'h0000);
    rreg(SPCS_STS1_OFS, 16'h0000);
    wreg(3'h5, 16'hffff);
    rreg(3'h5, 16'h0000);
    chk({comma, crcen, fib, tbi}, 16'hA);
    wreg(SPCS_CTL4_OFS, 16'h0007);
    rreg(SPCS_CTL4_OFS, 16'h0007);
    @(posedge clk_i);
    ce <= 1'b0;
    wreg(SPCS_CTL4_OFS, 16'h00ff);
    @(posedge clk_i);
    ce <= 1'b1;
    rreg(SPCS_CTL4_OFS, 16'h0007);
    $display("test reset_map done");
  endtask
  task automatic t_ctl_one();
    wreg(SPCS_CTL1_OFS, 16'h0002);
    @(negedge clk_i);
    chk({comma, crcen, fib, tbi}, 16'h5);
    @(posedge clk_i);
    pwrdn <= 1'b1;
    @(negedge clk_i);
    chk(pllpd, 16'h1);
    wreg(SPCS_CTL1_OFS, 16'h0060);
    chk({pllpd, sgphy, tbi, adv}, 16'h15);
    wreg(SPCS_CTL1_OFS, 16'h0005);
    i_spcs_far_model.set_line(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(negedge clk_i);
    chk(sya, 16'h0);
    wreg(SPCS_CTL1_OFS, 16'h000d);
    repeat (4) @(negedge clk_i);
    chk(sya, 16'h1);
    wreg(SPCS_CTL1_OFS, 16'h0004);
    @(negedge clk_i);
    chk({sya, fib}, 16'h2);
    @(posedge clk_i);
    pwrdn <= 1'b0;
    $display("test ctl_one done");
  endtask
  task automatic t_autodet();
    wreg(SPCS_CTL1_OFS, 16'h0015);
    i_spcs_far_model.send_page(1'b0);
    repeat (2) @(negedge clk_i);
    chk(fib, 16'h1);
    i_spcs_far_model.send_page(1'b1);
    repeat (2) @(negedge clk_i);
    chk(fib, 16'h0);
    i_spcs_far_model.send_page(1'b0);
    repeat (2) @(negedge clk_i);
    chk(fib, 16'h1);
    wreg(SPCS_CTL1_OFS, 16'h0185);
    $display("test autodet done");
  endtask
  task automatic t_sticky();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      err <= 8'h1 << k;
      @(posedge clk_i);
      err <= 8'h0;
      rreg(SPCS_STS1_OFS, 16'h0100 << k);
      rreg(SPCS_STS1_OFS, 16'h0000);
    end
    $display("test sticky done");
  endtask
  task automatic t_counters();
    @(posedge clk_i);
    ber <= 1'b1;
    crc <= 1'b1;
    repeat (3) @(posedge clk_i);
    ber <= 1'b0;
    crc <= 1'b0;
    @(negedge clk_i);
    chk({i_spcs_ctrl.ber_reg, i_spcs_ctrl.pkt_reg}, 16'h0303);
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST | 16'h4800);
    repeat (4) @(negedge clk_i);
    chk({i_spcs_ctrl.ber_reg, i_spcs_ctrl.pkt_reg}, 16'h0007);
    rreg(SPCS_CTL2_OFS, SPCS_CTL2_RST | 16'h0800);
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST);
    $display("test counters done");
  endtask
  task automatic t_link();
    i_spcs_far_model.set_line(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (10) @(negedge clk_i);
    chk(lnk, 16'h0);
    repeat (20) @(negedge clk_i);
    chk(lnk, 16'h1);
    i_spcs_far_model.set_cw(1'b1);
    repeat (2) @(negedge clk_i);
    chk({anact, lnk}, 16'h2);
    wreg(SPCS_CTL2_OFS, 16'h0006);
    chk({anact, lnk}, 16'h0);
    i_spcs_far_model.set_cw(1'b0);
    repeat (2) @(negedge clk_i);
    chk(lnk, 16'h1);
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST);
    chk({anact, lnk}, 16'h1);
    i_spcs_far_model.set_line(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (3) @(negedge clk_i);
    chk(lnk, 16'h0);
    $display("test link done");
  endtask
  task automatic t_tx_path();
    i_spcs_far_model.set_line(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    fdx <= 1'b0;
    @(negedge clk_i);
    chk({txen, crs}, 16'h0);
    wreg(SPCS_CTL2_OFS, 16'h06a7);
    chk({txen, txb, rxb}, 16'h7);
    chk(crs, 16'h1);
    wreg(SPCS_CTL3_OFS, 16'h2002);
    chk({txen, crs}, 16'h2);
    i_spcs_far_model.set_line(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    @(negedge clk_i);
    chk(crs, 16'h1);
    wreg(SPCS_CTL3_OFS, 16'h0202);
    i_spcs_far_model.set_line(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    i_spcs_far_model.set_line(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    @(negedge clk_i);
    chk(txen, 16'h0);
    repeat (7) @(negedge clk_i);
    chk({txen, crs}, 16'h3);
    @(posedge clk_i);
    fdx <= 1'b1;
    @(negedge clk_i);
    chk({txen, crs}, 16'h2);
    wreg(SPCS_CTL3_OFS, SPCS_CTL3_RST);
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST);
    i_spcs_far_model.set_line(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    fdx <= 1'b0;
    $display("test tx_path done");
  endtask
  task automatic t_fifo();
    for (int c = 0; c < 4; c++) begin
      wreg(SPCS_CTL3_OFS, 16'(c << 1));
      chk({dtx, drx}, (c == 0) ? 16'h0 : (c == 1) ? 16'h5 : 16'ha);
    end
    wreg(SPCS_CTL3_OFS, 16'h0062);
    chk({dtx, drx}, 16'hf);
    wreg(SPCS_CTL3_OFS, 16'h0003);
    repeat (50) @(negedge clk_i);
    chk(txfr, 16'h1);
    wreg(SPCS_CTL3_OFS, 16'h0002);
    chk(txfr, 16'h0);
    $display("test fifo done");
  endtask
  task automatic t_an_err();
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST | 16'h0008);
    i_spcs_far_model.set_cw(1'b1);
    repeat (4100) @(negedge clk_i);
    chk({zcfg, rf, fib}, 16'h7);
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST | 16'h0018);
    chk(rf, 16'h0);
    i_spcs_far_model.send_page(1'b0);
    repeat (2) @(negedge clk_i);
    chk(zcfg, 16'h0);
    i_spcs_far_model.set_cw(1'b0);
    wreg(SPCS_CTL2_OFS, SPCS_CTL2_RST);
    $display("test an_err done");
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    {rst_b_i, rd, wr, pwrdn, fdx, ber, crc} = 7'h0;
    addr = 3'h0;
    wdata = 16'h0000;
    err = 8'h0;
    ce = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset_map();
    t_ctl_one();
    t_autodet();
    t_sticky();
    t_counters();
    t_link();
    t_tx_path();
    t_fifo();
    t_an_err();
    tally_and_finish();
  end
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
endmodule

// file: tb/spcs_far_model.sv
`timescale 1ns/1ns
module spcs_far_model (
  // Clock
  input  wire logic clk_i,
  // Link partner and MAC side
  output logic      rx_sync_o,
  output logic      rx_idle_o,
  output logic      rx_cw_o,
  output logic      rx_page_o,
  output logic      rx_page_sel0_o,
  output logic      rx_active_o,
  output logic      mac_tx_en_o,
  output logic      sig_det_o
);
  logic sel_q;
  logic tog_q;
  // Selector is only meaningful with a page; otherwise it wanders
  assign rx_page_sel0_o = rx_page_o ? sel_q : tog_q;
  initial begin
    {rx_sync_o, rx_idle_o, rx_cw_o, rx_page_o} = 4'h0;
    {rx_active_o, mac_tx_en_o, sig_det_o, sel_q, tog_q} = 5'h0;
  end
  always @(posedge clk_i) tog_q <= ~tog_q;
  task automatic send_page(input logic sel);
    @(posedge clk_i);
    rx_page_o <= 1'b1;
    sel_q     <= sel;
    @(posedge clk_i);
    rx_page_o <= 1'b0;
  endtask
  task automatic set_cw(input logic c);
    @(posedge clk_i);
    rx_cw_o <= c;
  endtask
  task automatic set_line(input logic sy, id, ac, tx, sd);
    @(posedge clk_i);
    {rx_sync_o, rx_idle_o, rx_active_o, mac_tx_en_o, sig_det_o} <=
      {sy, id, ac, tx, sd};
  endtask
endmodule
